//--- logic/fifo_error_threshold_flags.sv
// fifo write/read error and threshold flags with an axi4-lite register slave
// How it works
// - watermark mode: sample refused during a host read sets write error, bit 6.
// - watermark mode: fifo full at watermark until emptied; new samples dropped, write error.
// - watermark drop sets write error exactly like the overrun flag.
// - streaming mode: write error only when a host read blocks the sample.
// - write error clears when the fifo becomes empty, in both modes.
// - write error interrupt line follows the write error flag in the same cycle.
// - read request refused during a sample write sets read error.
// - read error clears on a later granted read or when the fifo empties.
// - read error interrupt line follows the read error flag.
// - enabled channel, stored sample at or above upper limit sets upper flag, bit 4.
// - upper flag clears when the fifo empties; its interrupt line follows it.
// - lower flag, bit 3, marks a stored sample at or below the lower limit.
// - flags rise only in watermark or streaming mode.
// - watermark code zero means 256 samples, other codes mean that many.
// - streaming at full drops the oldest sample and sets overrun.
// - enabled channel at or below lower limit sets lower flag; emptying clears it.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module fifo_error_threshold_flags
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [fifo_flags_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [fifo_flags_pkg::DATA_W-1:0] wdata,
    input wire logic [fifo_flags_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [fifo_flags_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [fifo_flags_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sampleValid,
    input wire logic [fifo_flags_pkg::SAMPLE_W-1:0] sampleData,
    input wire logic [fifo_flags_pkg::CHAN_W-1:0] sampleChan,
    input wire logic hostReadReq,
    output logic hostReadGrant,
    output logic writeErrIrq,
    output logic readErrIrq,
    output logic upperLimitIrq,
    output logic lowerLimitIrq,
    output logic irq
);
    import fifo_flags_pkg::*;
    function automatic logic regHit(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr & WORD_MASK;
        regHit = (word == OFS_CONTROL) || (word == OFS_UPPER) || (word == OFS_LOWER) ||
                 (word == OFS_LIMIT_EN) || (word == OFS_FLAGS) || (word == OFS_IRQ_STATUS) ||
                 (word == OFS_IRQ_MASK) || (word == OFS_LEVEL);
    endfunction : regHit

    function automatic logic [DATA_W-1:0] applyStrobe(input logic [DATA_W-1:0] old,
                                                      input logic [DATA_W-1:0] data,
                                                      input logic [STRB_W-1:0] strb);
        applyStrobe = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                applyStrobe[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction : applyStrobe

    logic awready_ff, awHeld_ff, wready_ff, wHeld_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [DATA_W-1:0] wData_ff, rdata_ff;
    logic [STRB_W-1:0] wStrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [DATA_W-1:0] ctrl_ff, upper_ff, lower_ff, limitEn_ff, irqMask_ff, nxt_irqMask;
    logic [FLAGS_W-1:0] irqStatus_ff, nxt_irqStatus, irqEvents, w1cBits;
    logic irq_ff, hostReadGrant_ff;
    logic writeErr_ff, readErr_ff, upperHit_ff, lowerHit_ff, overrun_ff;
    port_state_type portState_ff;
    logic [LEVEL_W-1:0] level;
    logic wmFull, doWrite, modeActive, sampleBlocked, wmDrop, store, streamOverwrite;
    logic readRefused, readGrant, emptying, upperSet, lowerSet, writeErrSet, overrunSet;
    logic [1:0] modeSel;
    logic [WM_W-1:0] watermark;
    logic [FLAGS_W-1:0] flagsWord;

    assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            awready_ff <= 1'b0;
            awHeld_ff <= 1'b0;
            awAddr_ff <= OFS_CONTROL;
        end else if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (bvalid_ff && bready) begin
            awready_ff <= 1'b1;
            awHeld_ff <= 1'b0;
        end else if (!awHeld_ff) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wready_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            wData_ff <= REG_RESET;
            wStrb_ff <= '0;
        end else if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end else if (bvalid_ff && bready) begin
            wready_ff <= 1'b1;
            wHeld_ff <= 1'b0;
        end else if (!wHeld_ff) begin
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= regHit(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // flags and level words ignore writes: they are read only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_ff <= REG_RESET;
            upper_ff <= REG_RESET;
            lower_ff <= REG_RESET;
            limitEn_ff <= REG_RESET;
            irqMask_ff <= REG_RESET;
        end else if (doWrite) begin
            case (awAddr_ff & WORD_MASK)
                OFS_CONTROL: ctrl_ff <= applyStrobe(ctrl_ff, wData_ff, wStrb_ff) & CTRL_MASK;
                OFS_UPPER: upper_ff <= applyStrobe(upper_ff, wData_ff, wStrb_ff) & LIMIT_MASK;
                OFS_LOWER: lower_ff <= applyStrobe(lower_ff, wData_ff, wStrb_ff) & LIMIT_MASK;
                OFS_LIMIT_EN: limitEn_ff <= applyStrobe(limitEn_ff, wData_ff, wStrb_ff) & ENABLE_MASK;
                OFS_IRQ_MASK: irqMask_ff <= nxt_irqMask;
                default: ;
            endcase
        end
    end

    assign w1cBits = (doWrite && (awAddr_ff & WORD_MASK) == OFS_IRQ_STATUS && wStrb_ff[0]) ?
                     wData_ff[FLAGS_W-1:0] : FLAGS_RESET;
    assign nxt_irqMask = (doWrite && (awAddr_ff & WORD_MASK) == OFS_IRQ_MASK) ?
                         applyStrobe(irqMask_ff, wData_ff, wStrb_ff) & IRQ_MASK_BITS : irqMask_ff;

    assign flagsWord = {1'b0, writeErr_ff, readErr_ff, upperHit_ff, lowerHit_ff, overrun_ff, 2'b00};
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= REG_RESET;
            rresp_ff <= RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr & WORD_MASK)
                OFS_CONTROL: rdata_ff <= ctrl_ff;
                OFS_UPPER: rdata_ff <= upper_ff;
                OFS_LOWER: rdata_ff <= lower_ff;
                OFS_LIMIT_EN: rdata_ff <= limitEn_ff;
                OFS_FLAGS: rdata_ff <= {{(DATA_W-FLAGS_W){1'b0}}, flagsWord};
                OFS_IRQ_STATUS: rdata_ff <= {{(DATA_W-FLAGS_W){1'b0}}, irqStatus_ff};
                OFS_IRQ_MASK: rdata_ff <= irqMask_ff;
                OFS_LEVEL: rdata_ff <= {{(DATA_W-LEVEL_W){1'b0}}, level};
                default: rdata_ff <= REG_RESET;
            endcase
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    assign modeSel = ctrl_ff[CTRL_MODE_LSB +: 2];
    assign watermark = ctrl_ff[CTRL_WM_LSB +: WM_W];
    assign modeActive = (modeSel == MODE_WATERMARK) || (modeSel == MODE_STREAM);
    assign sampleBlocked = sampleValid && modeActive && portState_ff == PORT_READING;
    assign wmDrop = sampleValid && modeSel == MODE_WATERMARK && wmFull && !sampleBlocked;
    assign store = sampleValid && modeActive && !sampleBlocked && !wmDrop;
    assign streamOverwrite = store && modeSel == MODE_STREAM && level == FIFO_DEPTH;
    // the writer wins a same-cycle clash; the read is the one refused
    assign readRefused = hostReadReq && (store || portState_ff == PORT_WRITING);
    assign readGrant = hostReadReq && !readRefused && level != LEVEL_ZERO;
    assign emptying = readGrant && level == LEVEL_ONE;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            portState_ff <= PORT_IDLE;
        end else begin
            case (portState_ff)
                PORT_IDLE, PORT_WRITING, PORT_READING: begin
                    if (store) begin
                        portState_ff <= PORT_WRITING;
                    end else if (readGrant) begin
                        portState_ff <= PORT_READING;
                    end else begin
                        portState_ff <= PORT_IDLE;
                    end
                end
                default: portState_ff <= PORT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hostReadGrant_ff <= 1'b0;
        end else begin
            hostReadGrant_ff <= readGrant;
        end
    end
    fifo_level_tracker levelTracker (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pushEn(store),
        .popEn(readGrant),
        .modeSel(modeSel),
        .watermark(watermark),
        .level(level),
        .wmFull(wmFull)
    );
    // status flags: a set wins over a clear
    // limits compare unsigned against the channel that made the sample
    assign upperSet = store && limitEn_ff[sampleChan] && {8'h00, sampleData} >= upper_ff;
    assign lowerSet = store && limitEn_ff[sampleChan] && {8'h00, sampleData} <= lower_ff;
    assign writeErrSet = sampleBlocked || wmDrop;
    assign overrunSet = wmDrop || streamOverwrite;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            writeErr_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            writeErr_ff <= writeErrSet || (writeErr_ff && !emptying);
            overrun_ff <= overrunSet || (overrun_ff && !emptying);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readErr_ff <= 1'b0;
        end else begin
            readErr_ff <= (readRefused && modeActive) || (readErr_ff && !readGrant);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            upperHit_ff <= 1'b0;
            lowerHit_ff <= 1'b0;
        end else begin
            upperHit_ff <= upperSet || (upperHit_ff && !emptying);
            lowerHit_ff <= lowerSet || (lowerHit_ff && !emptying);
        end
    end

    always_comb begin
        irqEvents = FLAGS_RESET;
        irqEvents[BIT_WRITE_ERR] = writeErrSet;
        irqEvents[BIT_READ_ERR] = readRefused && modeActive;
        irqEvents[BIT_UPPER] = upperSet;
        irqEvents[BIT_LOWER] = lowerSet;
        irqEvents[BIT_OVERRUN] = overrunSet;
        nxt_irqStatus = (irqStatus_ff & ~w1cBits) | irqEvents;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irqStatus_ff <= FLAGS_RESET;
            irq_ff <= 1'b0;
        end else begin
            irqStatus_ff <= nxt_irqStatus;
            irq_ff <= |(nxt_irqStatus & nxt_irqMask[FLAGS_W-1:0]);
        end
    end
    // the per-flag lines are the flag flip-flops themselves
    assign writeErrIrq = writeErr_ff;
    assign readErrIrq = readErr_ff;
    assign upperLimitIrq = upperHit_ff;
    assign lowerLimitIrq = lowerHit_ff;
    assign irq = irq_ff;
    assign hostReadGrant = hostReadGrant_ff;
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    blocked_write_a: assert property (sampleBlocked |=> writeErrIrq && irqStatus_ff[BIT_WRITE_ERR])
        else $error("sample blocked by a read did not raise write error");
    wm_drop_a: assert property (wmDrop && !readGrant |=> writeErr_ff && overrun_ff && $stable(level))
        else $error("watermark drop changed level or missed the flags");
    empty_clear_a: assert property (emptying && !sampleValid |=> {level, flagsWord} == '0)
        else $error("emptying the fifo left a flag set");
    read_refuse_a: assert property (hostReadReq && store && modeActive |=> readErr_ff && !hostReadGrant)
        else $error("clashing read was not refused and flagged");
    grant_clear_a: assert property (hostReadGrant |-> !readErr_ff)
        else $error("granted read left read error set");
    upper_hit_a: assert property (upperSet |=> upperLimitIrq && irqStatus_ff[BIT_UPPER])
        else $error("upper limit hit not flagged");
    stream_full_a: assert property (streamOverwrite |=> level == FIFO_DEPTH && overrun_ff)
        else $error("streaming overwrite lost depth or overrun");
    mode_gate_a: assert property (!modeActive |=> !$rose(writeErr_ff) && !$rose(upperHit_ff))
        else $error("flag raised outside watermark or streaming mode");
    irq_follow_a: assert property (irq == (|(irqStatus_ff & irqMask_ff[FLAGS_W-1:0])))
        else $error("interrupt line disagrees with unmasked status");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    stream_cover_c: cover property (streamOverwrite);
    wm_drop_cover_c: cover property (wmDrop ##[1:20] emptying);
    clash_cover_c: cover property (hostReadReq && sampleValid && modeActive);
endmodule : fifo_error_threshold_flags

//--- logic/fifo_flags_pkg.sv
// shared constants, register map and types for the fifo error and threshold flag block
package fifo_flags_pkg;
    localparam int SAMPLE_W = 24;
    localparam int CHAN_W = 4;
    localparam int NUM_CHAN = 16;
    localparam int LEVEL_W = 9;
    localparam int WM_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int FLAGS_W = 8;

    localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 9'h100;
    localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 9'h000;
    localparam logic [LEVEL_W-1:0] LEVEL_ONE = 9'h001;
    localparam logic [WM_W-1:0] WM_WHOLE_CODE = 8'h00;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_WATERMARK = 2'h1;
    localparam logic [1:0] MODE_STREAM = 2'h2;

    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIMIT_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h1C;
    localparam logic [ADDR_W-1:0] WORD_MASK = 8'hFC;

    // writable bits of each register, reset value of all of them is zero
    localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_FF03;
    localparam logic [DATA_W-1:0] LIMIT_MASK = 32'h00FF_FFFF;
    localparam logic [DATA_W-1:0] ENABLE_MASK = 32'h0000_FFFF;
    localparam logic [DATA_W-1:0] IRQ_MASK_BITS = 32'h0000_007C;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WM_LSB = 8;

    localparam int BIT_WRITE_ERR = 6;
    localparam int BIT_READ_ERR = 5;
    localparam int BIT_UPPER = 4;
    localparam int BIT_LOWER = 3;
    localparam int BIT_OVERRUN = 2;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PORT_IDLE = 3'b001,
        PORT_WRITING = 3'b010,
        PORT_READING = 3'b100
    } port_state_type;

    // watermark field: zero stands for the whole fifo
    function automatic logic [LEVEL_W-1:0] wmDepth(input logic [WM_W-1:0] code);
        wmDepth = (code == WM_WHOLE_CODE) ? FIFO_DEPTH : {1'b0, code};
    endfunction : wmDepth
endpackage : fifo_flags_pkg

//--- logic/fifo_level_tracker.sv
// occupancy counter of the sample fifo with the watermark-full latch
`timescale 1ns/1ps
module fifo_level_tracker
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pushEn,
    input wire logic popEn,
    input wire logic [1:0] modeSel,
    input wire logic [fifo_flags_pkg::WM_W-1:0] watermark,
    output logic [fifo_flags_pkg::LEVEL_W-1:0] level,
    output logic wmFull
);
    import fifo_flags_pkg::*;
    logic [LEVEL_W-1:0] level_ff;
    logic [LEVEL_W-1:0] nxt_level;
    logic wmFull_ff;

    // a push at full depth is the streaming overwrite: the count stays put
    always_comb begin
        nxt_level = level_ff;
        if (popEn && level_ff != LEVEL_ZERO) begin
            nxt_level = level_ff - LEVEL_ONE;
        end else if (pushEn && level_ff != FIFO_DEPTH) begin
            nxt_level = level_ff + LEVEL_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            level_ff <= LEVEL_ZERO;
        end else begin
            level_ff <= nxt_level;
        end
    end

    // once the watermark is met the fifo counts as full until drained
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wmFull_ff <= 1'b0;
        end else if (nxt_level == LEVEL_ZERO) begin
            wmFull_ff <= 1'b0;
        end else if (modeSel == MODE_WATERMARK && nxt_level >= wmDepth(watermark)) begin
            wmFull_ff <= 1'b1;
        end
    end

    assign level = level_ff;
    assign wmFull = wmFull_ff;
endmodule : fifo_level_tracker

//--- verification/host_reader_model.sv
// host-side reader model: issues fifo read requests and counts the grants it receives
`timescale 1ns/1ps
module host_reader_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hostReadGrant,
    output logic hostReadReq,
    output int grantCount
);
    initial hostReadReq = 1'h0;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            grantCount <= 0;
        end else if (hostReadGrant) begin
            grantCount <= grantCount + 1;
        end
    end
    // call just after a rising edge; the request is taken on the next edge
    task automatic pulse();
        hostReadReq <= 1'h1;
        @(posedge ref_clk);
        hostReadReq <= 1'h0;
    endtask : pulse
endmodule : host_reader_model

//--- verification/fifo_error_threshold_flags_tb.sv
// self-checking bench for the fifo error and threshold flag block
`timescale 1ns/1ps
module fifo_error_threshold_flags_tb;
    import fifo_flags_pkg::*;
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    // responses are always accepted at once, so bready and rready never toggle
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1, sampleValid = 1'h0;
    logic [DATA_W-1:0] wdata = '0;
    logic [STRB_W-1:0] wstrb = 4'hF;
    logic [SAMPLE_W-1:0] sampleData = '0;
    logic [CHAN_W-1:0] sampleChan = '0;
    logic awready, wready, bvalid, arready, rvalid, hostReadReq, hostReadGrant;
    logic writeErrIrq, readErrIrq, upperLimitIrq, lowerLimitIrq, irq;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rdata;
    int grantCount;
    int miscompares = 0;
    int compares = 0;

    fifo_error_threshold_flags DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sampleValid(sampleValid), .sampleData(sampleData),
        .sampleChan(sampleChan), .hostReadReq(hostReadReq), .hostReadGrant(hostReadGrant),
        .writeErrIrq(writeErrIrq), .readErrIrq(readErrIrq), .upperLimitIrq(upperLimitIrq),
        .lowerLimitIrq(lowerLimitIrq), .irq(irq));
    host_reader_model host (.ref_clk(ref_clk), .sys_rst(sys_rst), .hostReadGrant(hostReadGrant),
        .hostReadReq(hostReadReq), .grantCount(grantCount));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [DATA_W-1:0] bitOf(input int b);
        bitOf = 32'h1 << b;
    endfunction : bitOf

    task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (bvalid === 1'h1) break;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end
        if (n == 50) begin
            miscompares++;
            print_verdict();
        end
        check({30'h0, bresp}, {30'h0, er});
    endtask : axiWrite

    task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (rvalid === 1'h1) break;
            if (arready === 1'h1) arvalid <= 1'h0;
        end
        if (n == 50) begin
            miscompares++;
            print_verdict();
        end
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
    endtask : axiRead

    // valid stays high for n back-to-back samples instead of being dropped and raised in one step
    task automatic sample(input logic [CHAN_W-1:0] c, input logic [SAMPLE_W-1:0] v, input int n = 1);
        sampleChan <= c;
        sampleData <= v;
        sampleValid <= 1'h1;
        repeat (n) @(posedge ref_clk);
        sampleValid <= 1'h0;
    endtask : sample

    // an idle cycle after each request keeps the port free for the next one
    task automatic drain(input int n);
        repeat (n) begin
            host.pulse();
            @(posedge ref_clk);
        end
    endtask : drain

    task automatic resetScenario();
        axiRead(OFS_FLAGS, REG_RESET, RESP_OKAY);
        axiWrite(OFS_FLAGS, 32'h0000_00FF, RESP_OKAY);
        axiRead(OFS_FLAGS, REG_RESET, RESP_OKAY);
        axiRead(8'h40, REG_RESET, RESP_SLVERR);
        axiWrite(8'h40, 32'h0000_0001, RESP_SLVERR);
    endtask : resetScenario

    task automatic streamScenario();
        axiWrite(OFS_UPPER, 32'h0000_0064, RESP_OKAY);
        axiWrite(OFS_LOWER, 32'h0000_000A, RESP_OKAY);
        axiWrite(OFS_LIMIT_EN, 32'h0000_0008, RESP_OKAY);
        axiWrite(OFS_CONTROL, {30'h0, MODE_STREAM}, RESP_OKAY);
        sample(4'h3, 24'h000064);
        @(posedge ref_clk);
        sample(4'h5, 24'h000000);
        axiRead(OFS_FLAGS, bitOf(BIT_UPPER), RESP_OKAY);
        sample(4'h3, 24'h00000A);
        axiRead(OFS_FLAGS, bitOf(BIT_UPPER) | bitOf(BIT_LOWER), RESP_OKAY);
        fork
            sample(4'h5, 24'h000020);
            host.pulse();
        join
        axiRead(OFS_FLAGS, bitOf(BIT_UPPER) | bitOf(BIT_LOWER) | bitOf(BIT_READ_ERR), RESP_OKAY);
        check({31'h0, readErrIrq}, 32'h1);
        axiRead(OFS_LEVEL, 32'h4, RESP_OKAY);
        host.pulse();
        sample(4'h5, 24'h000020);
        axiRead(OFS_FLAGS, bitOf(BIT_UPPER) | bitOf(BIT_LOWER) | bitOf(BIT_WRITE_ERR), RESP_OKAY);
        check({28'h0, writeErrIrq, readErrIrq, upperLimitIrq, lowerLimitIrq}, 32'hB);
        axiRead(OFS_LEVEL, 32'h3, RESP_OKAY);
        drain(3);
        axiRead(OFS_FLAGS, REG_RESET, RESP_OKAY);
        check({28'h0, writeErrIrq, readErrIrq, upperLimitIrq, lowerLimitIrq}, 32'h0);
        check(grantCount, 32'h4);
    endtask : streamScenario

    task automatic streamFullScenario();
        sample(4'h5, 24'h000020, 257);
        axiRead(OFS_LEVEL, {23'h0, FIFO_DEPTH}, RESP_OKAY);
        axiRead(OFS_FLAGS, bitOf(BIT_OVERRUN), RESP_OKAY);
        drain(256);
        axiRead(OFS_LEVEL, REG_RESET, RESP_OKAY);
    endtask : streamFullScenario

    task automatic watermarkScenario();
        axiWrite(OFS_IRQ_STATUS, 32'h0000_00FF, RESP_OKAY);
        axiWrite(OFS_CONTROL, {16'h0, 8'h02, 6'h0, MODE_WATERMARK}, RESP_OKAY);
        sample(4'h5, 24'h000020, 3);
        axiRead(OFS_LEVEL, 32'h2, RESP_OKAY);
        axiRead(OFS_FLAGS, bitOf(BIT_WRITE_ERR) | bitOf(BIT_OVERRUN), RESP_OKAY);
        drain(2);
        axiRead(OFS_FLAGS, REG_RESET, RESP_OKAY);
        axiWrite(OFS_IRQ_MASK, bitOf(BIT_OVERRUN), RESP_OKAY);
        axiRead(OFS_IRQ_STATUS, bitOf(BIT_WRITE_ERR) | bitOf(BIT_OVERRUN), RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        axiWrite(OFS_IRQ_STATUS, bitOf(BIT_OVERRUN), RESP_OKAY);
        axiRead(OFS_IRQ_STATUS, bitOf(BIT_WRITE_ERR), RESP_OKAY);
        check({31'h0, irq}, 32'h0);
    endtask : watermarkScenario

    // mode 3 must behave like off: nothing stored, no flag raised
    task automatic offScenario(input logic [1:0] m);
        axiWrite(OFS_CONTROL, {30'h0, m}, RESP_OKAY);
        sample(4'h3, 24'hFFFFFF);
        axiRead(OFS_LEVEL, REG_RESET, RESP_OKAY);
        axiRead(OFS_FLAGS, REG_RESET, RESP_OKAY);
    endtask : offScenario

    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        resetScenario();
        streamScenario();
        streamFullScenario();
        watermarkScenario();
        offScenario(MODE_OFF);
        offScenario(2'h3);
        print_verdict();
    end
endmodule : fifo_error_threshold_flags_tb
